/* File: src/ahrs_pkg.sv */
// Purpose: constants and types of the axis home-return sequencer
// Assumes: apb with 32-bit data, one word per register
// Notes: shared by the sequencer, its checker, the amplifier model and the bench
//
// Notes on behaviour
// R1: near-home rise stops motor, sets home
// R2: rear edge: near-home fall, then reference rise
// R3: index already high at start never counts
// R4: rear-edge method offers index, latch two, three
// R5: opposite limit rise, reverse, index rise stops
// R6: limit rise in homing direction stops motor
// R7: index-only: move, first index rise stops
// R8: latch two or three single-edge methods
// R9: torque above threshold for duration stops axis
// R10: contact detected, reverse, index rise stops
// R11: reversal methods offer latch two, three variants
// R12: data-set takes current position, no motion
// R13: amplifier faults edge methods on default pattern
// R14: latch methods need default input assignment
// R15: unsupported method rejected with error, no motion
// R16: stop position latched in same cycle as stop
// R17: latch variants replace index as reference edge
`default_nettype none

package ahrs_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT = 8'h08;
   localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
   localparam logic [7:0] ADDR_TORQUE_THR = 8'h10;
   localparam logic [7:0] ADDR_CONTACT_CYC = 8'h14;
   localparam logic [7:0] ADDR_HOME_POS = 8'h18;
   localparam logic [7:0] ADDR_COORD = 8'h1c;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_METHOD_LSB = 0;
   localparam int CTRL_DIR_BIT = 4;
   localparam int CTRL_PATB_BIT = 5;
   localparam int CTRL_START_BIT = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_ERR_BIT = 2;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_ERR_BIT = 1;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [3:0] RST_METHOD = 4'h0;
   localparam logic [1:0] RST_INT_MASK = 2'h0;
   localparam logic [15:0] RST_TORQUE_THR = 16'hffff;
   localparam logic [15:0] RST_CONTACT_CYC = 16'h0001;

   // ------------------------------------------------------------
   // homing methods
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      M_NH_EDGE = 4'h0,
      M_NH_REAR_IDX = 4'h1,
      M_NH_REAR_L2 = 4'h2,
      M_NH_REAR_L3 = 4'h3,
      M_LIM_REV_IDX = 4'h4,
      M_LIM_REV_L2 = 4'h5,
      M_LIM_REV_L3 = 4'h6,
      M_LIM_ONLY = 4'h7,
      M_IDX_ONLY = 4'h8,
      M_L2_ONLY = 4'h9,
      M_L3_ONLY = 4'ha,
      M_CONTACT = 4'hb,
      M_CREV_IDX = 4'hc,
      M_CREV_L2 = 4'hd,
      M_CREV_L3 = 4'he,
      M_DATA_SET = 4'hf
   } ahrs_method_type;

   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_SEEK = 3'b010,
      S_REF = 3'b100
   } ahrs_state_type;

   // switch and encoder pins, all asynchronous to pclk
   typedef struct packed {
      logic near_home_switch;
      logic positive_overtravel_limit;
      logic negative_overtravel_limit;
      logic index_pulse;
      logic external_latch_two;
      logic external_latch_three;
   } ahrs_pins_type;

   localparam int PIN_W = 6;

endpackage

`default_nettype wire

/* File: src/ahrs_edge_sync.sv */
// Purpose: two-flop synchroniser with rise and fall detection
// Assumes: inputs asynchronous to clk
// Notes: edges come from the second and third stages only
`default_nettype none

module ahrs_edge_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins and results
   input wire logic [W-1:0] raw,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] s1_r, s2_r, s3_r;
   logic [W-1:0] s1_nxt, s2_nxt, s3_nxt;

   always_comb begin
      s1_nxt = raw;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end

   assign level = s2_r;
   assign rise = s2_r & ~s3_r;
   assign fall = ~s2_r & s3_r;
endmodule // ahrs_edge_sync

`default_nettype wire

/* File: src/ahrs_sequencer.sv */
// Purpose: home-return sequencer for one servo axis, apb slave
// Assumes: axis_position and motor_torque come from pclk logic
// Notes: motor_run and motor_dir command the axis; dir 1 is positive
//
// Chosen here: register access over APB and the register addresses.
`default_nettype none

module ahrs_sequencer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // axis feedback
   input wire logic [31:0] axis_position,
   input wire logic [15:0] motor_torque,
   input wire ahrs_pkg::ahrs_pins_type pins,
   // axis command
   output logic motor_run,
   output logic motor_dir,
   // interrupt
   output logic irq
);
   // ------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------
   ahrs_pkg::ahrs_pins_type rise, fall;

   ahrs_edge_sync #(.W(ahrs_pkg::PIN_W)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .raw(pins),
      .level(),
      .rise(rise),
      .fall(fall)
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ahrs_pkg::ahrs_method_type method_r, method_nxt;
   ahrs_pkg::ahrs_state_type state_r, state_nxt;
   logic dir_r, dir_nxt;
   logic patb_r, patb_nxt;
   logic run_r, run_nxt;
   logic mdir_r, mdir_nxt;
   logic done_r, done_nxt;
   logic err_r, err_nxt;
   logic [1:0] int_stat_r, int_stat_nxt;
   logic [1:0] int_mask_r, int_mask_nxt;
   logic [15:0] thr_r, thr_nxt;
   logic [15:0] dur_r, dur_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [31:0] home_r, home_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;

   logic wr_en, setup, start, mapped;
   logic supported, ref_rise, fwd_lim_rise, opp_lim_rise, contact_hit;
   logic ev_done, ev_err;
   ahrs_pkg::ahrs_method_type req_method;
   logic [31:0] rd_mux;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & ~pslverr_r;
   assign start = wr_en && paddr == ahrs_pkg::ADDR_CTRL && pwdata[ahrs_pkg::CTRL_START_BIT];
   assign req_method = ahrs_pkg::ahrs_method_type'(pwdata[ahrs_pkg::CTRL_METHOD_LSB +: 4]);

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         ahrs_pkg::ADDR_CTRL: begin
            rd_mux[ahrs_pkg::CTRL_METHOD_LSB +: 4] = method_r;
            rd_mux[ahrs_pkg::CTRL_DIR_BIT] = dir_r;
            rd_mux[ahrs_pkg::CTRL_PATB_BIT] = patb_r;
         end
         ahrs_pkg::ADDR_STATUS: begin
            rd_mux[ahrs_pkg::STAT_BUSY_BIT] = state_r != ahrs_pkg::S_IDLE;
            rd_mux[ahrs_pkg::STAT_DONE_BIT] = done_r;
            rd_mux[ahrs_pkg::STAT_ERR_BIT] = err_r;
         end
         ahrs_pkg::ADDR_INT_STAT: rd_mux[1:0] = int_stat_r;
         ahrs_pkg::ADDR_INT_MASK: rd_mux[1:0] = int_mask_r;
         ahrs_pkg::ADDR_TORQUE_THR: rd_mux[15:0] = thr_r;
         ahrs_pkg::ADDR_CONTACT_CYC: rd_mux[15:0] = dur_r;
         ahrs_pkg::ADDR_HOME_POS: rd_mux = home_r;
         ahrs_pkg::ADDR_COORD: rd_mux = axis_position - home_r; // R16
         default: mapped = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // method qualification
   // ------------------------------------------------------------
   always_comb begin
      case (req_method)
         // edge-only methods rely on the alternate assignment
         ahrs_pkg::M_NH_EDGE, ahrs_pkg::M_LIM_ONLY: supported = pwdata[ahrs_pkg::CTRL_PATB_BIT]; // R13
         ahrs_pkg::M_NH_REAR_L2, ahrs_pkg::M_NH_REAR_L3, ahrs_pkg::M_LIM_REV_L2, ahrs_pkg::M_LIM_REV_L3,
         ahrs_pkg::M_L2_ONLY, ahrs_pkg::M_L3_ONLY, ahrs_pkg::M_CREV_L2, ahrs_pkg::M_CREV_L3:
            supported = ~pwdata[ahrs_pkg::CTRL_PATB_BIT]; // R14
         default: supported = 1'b1; // R14
      endcase
   end

   // reference edge: index, or a latch input in its place
   always_comb begin
      case (method_r)
         ahrs_pkg::M_NH_REAR_L2, ahrs_pkg::M_LIM_REV_L2, ahrs_pkg::M_L2_ONLY, ahrs_pkg::M_CREV_L2:
            ref_rise = rise.external_latch_two; // R4 R8 R11 R17
         ahrs_pkg::M_NH_REAR_L3, ahrs_pkg::M_LIM_REV_L3, ahrs_pkg::M_L3_ONLY, ahrs_pkg::M_CREV_L3:
            ref_rise = rise.external_latch_three; // R4 R8 R11 R17
         // only a fresh rise counts, so an index held high at start is ignored
         default: ref_rise = rise.index_pulse; // R3 R7
      endcase
   end

   assign fwd_lim_rise = dir_r ? rise.positive_overtravel_limit : rise.negative_overtravel_limit;
   assign opp_lim_rise = dir_r ? rise.negative_overtravel_limit : rise.positive_overtravel_limit;
   assign contact_hit = cnt_r >= dur_r && dur_r != 16'h0000; // R9

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      method_nxt = method_r;
      state_nxt = state_r;
      dir_nxt = dir_r;
      patb_nxt = patb_r;
      run_nxt = run_r;
      mdir_nxt = mdir_r;
      done_nxt = done_r;
      err_nxt = err_r;
      int_mask_nxt = int_mask_r;
      thr_nxt = thr_r;
      dur_nxt = dur_r;
      home_nxt = home_r;
      ev_done = 1'b0;
      ev_err = 1'b0;
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      if (setup) begin
         prdata_nxt = pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_nxt = ~mapped;
      end

      // torque above threshold must persist; any dip restarts the count
      if (state_r == ahrs_pkg::S_SEEK && motor_torque > thr_r) begin
         cnt_nxt = (cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h0001; // R9
      end else begin
         cnt_nxt = 16'h0000;
      end

      if (wr_en) begin
         case (paddr)
            ahrs_pkg::ADDR_INT_MASK: int_mask_nxt = pwdata[1:0];
            ahrs_pkg::ADDR_TORQUE_THR: thr_nxt = pwdata[15:0];
            ahrs_pkg::ADDR_CONTACT_CYC: dur_nxt = pwdata[15:0];
            default: ;
         endcase
      end

      case (state_r)
         ahrs_pkg::S_IDLE: begin
            if (start) begin
               method_nxt = req_method;
               dir_nxt = pwdata[ahrs_pkg::CTRL_DIR_BIT];
               patb_nxt = pwdata[ahrs_pkg::CTRL_PATB_BIT];
               done_nxt = 1'b0;
               err_nxt = 1'b0;
               if (!supported) begin
                  err_nxt = 1'b1; // R15
                  ev_err = 1'b1; // R15
               end else if (req_method == ahrs_pkg::M_DATA_SET) begin
                  home_nxt = axis_position; // R12
                  done_nxt = 1'b1;
                  ev_done = 1'b1;
               end else begin
                  run_nxt = 1'b1;
                  mdir_nxt = pwdata[ahrs_pkg::CTRL_DIR_BIT] ^ (req_method inside {ahrs_pkg::M_LIM_REV_IDX,
                     ahrs_pkg::M_LIM_REV_L2, ahrs_pkg::M_LIM_REV_L3}); // R5
                  case (req_method)
                     ahrs_pkg::M_IDX_ONLY, ahrs_pkg::M_L2_ONLY, ahrs_pkg::M_L3_ONLY:
                        state_nxt = ahrs_pkg::S_REF; // R7 R8
                     default: state_nxt = ahrs_pkg::S_SEEK; // R3
                  endcase
               end
            end
         end
         ahrs_pkg::S_SEEK: begin
            case (method_r)
               ahrs_pkg::M_NH_EDGE: begin
                  if (rise.near_home_switch) begin
                     run_nxt = 1'b0; // R1
                     home_nxt = axis_position; // R1 R16
                     done_nxt = 1'b1;
                     ev_done = 1'b1;
                     state_nxt = ahrs_pkg::S_IDLE;
                  end
               end
               ahrs_pkg::M_NH_REAR_IDX, ahrs_pkg::M_NH_REAR_L2, ahrs_pkg::M_NH_REAR_L3: begin
                  if (fall.near_home_switch) begin
                     state_nxt = ahrs_pkg::S_REF; // R2
                  end
               end
               ahrs_pkg::M_LIM_REV_IDX, ahrs_pkg::M_LIM_REV_L2, ahrs_pkg::M_LIM_REV_L3: begin
                  if (opp_lim_rise) begin
                     mdir_nxt = dir_r; // R5
                     state_nxt = ahrs_pkg::S_REF;
                  end
               end
               ahrs_pkg::M_LIM_ONLY: begin
                  if (fwd_lim_rise) begin
                     run_nxt = 1'b0; // R6
                     home_nxt = axis_position; // R6 R16
                     done_nxt = 1'b1;
                     ev_done = 1'b1;
                     state_nxt = ahrs_pkg::S_IDLE;
                  end
               end
               ahrs_pkg::M_CONTACT: begin
                  if (contact_hit) begin
                     run_nxt = 1'b0; // R9
                     home_nxt = axis_position; // R9 R16
                     done_nxt = 1'b1;
                     ev_done = 1'b1;
                     state_nxt = ahrs_pkg::S_IDLE;
                  end
               end
               ahrs_pkg::M_CREV_IDX, ahrs_pkg::M_CREV_L2, ahrs_pkg::M_CREV_L3: begin
                  if (contact_hit) begin
                     mdir_nxt = ~dir_r; // R10
                     state_nxt = ahrs_pkg::S_REF;
                  end
               end
               default: begin
                  run_nxt = 1'b0;
                  state_nxt = ahrs_pkg::S_IDLE;
               end
            endcase
         end
         ahrs_pkg::S_REF: begin
            if (ref_rise) begin
               run_nxt = 1'b0; // R2 R5 R7 R10
               home_nxt = axis_position; // R16
               done_nxt = 1'b1;
               ev_done = 1'b1;
               state_nxt = ahrs_pkg::S_IDLE;
            end
         end
         default: begin
            run_nxt = 1'b0;
            state_nxt = ahrs_pkg::S_IDLE;
         end
      endcase

      // write-one clears, a new event in the same cycle wins
      int_stat_nxt = int_stat_r;
      if (wr_en && paddr == ahrs_pkg::ADDR_INT_STAT) begin
         int_stat_nxt = int_stat_r & ~pwdata[1:0];
      end
      if (ev_done) begin
         int_stat_nxt[ahrs_pkg::INT_DONE_BIT] = 1'b1;
      end
      if (ev_err) begin
         int_stat_nxt[ahrs_pkg::INT_ERR_BIT] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         method_r <= ahrs_pkg::ahrs_method_type'(ahrs_pkg::RST_METHOD);
         state_r <= ahrs_pkg::S_IDLE;
         dir_r <= 1'b0;
         patb_r <= 1'b0;
         run_r <= 1'b0;
         mdir_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
         int_stat_r <= 2'h0;
         int_mask_r <= ahrs_pkg::RST_INT_MASK;
         thr_r <= ahrs_pkg::RST_TORQUE_THR;
         dur_r <= ahrs_pkg::RST_CONTACT_CYC;
         cnt_r <= 16'h0000;
         home_r <= 32'h0000_0000;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         method_r <= method_nxt;
         state_r <= state_nxt;
         dir_r <= dir_nxt;
         patb_r <= patb_nxt;
         run_r <= run_nxt;
         mdir_r <= mdir_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
         int_stat_r <= int_stat_nxt;
         int_mask_r <= int_mask_nxt;
         thr_r <= thr_nxt;
         dur_r <= dur_nxt;
         cnt_r <= cnt_nxt;
         home_r <= home_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // zero-wait slave: data and error are captured in the setup cycle
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r & psel & penable;
   assign motor_run = run_r;
   assign motor_dir = mdir_r;
   assign irq = |(int_stat_r & int_mask_r);
endmodule // ahrs_sequencer

`default_nettype wire

/* File: tb/ahrs_amp_model.sv */
// Purpose: servo amplifier model that moves the axis and drives its switches
// Assumes: one count per pclk while motor_run is high
// Notes: a stopper clamps travel at +-205 and raises torque there
`default_nettype none

module ahrs_amp_model (
   // clock, reset and bench control
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic signed [31:0] load_val,
   // axis command
   input wire logic motor_run,
   input wire logic motor_dir,
   // feedback
   output logic signed [31:0] axis_position,
   output logic [15:0] motor_torque,
   output var ahrs_pkg::ahrs_pins_type pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic signed [31:0] p;
   logic at_stop;
   assign p = axis_position;
   assign at_stop = motor_run && (motor_dir ? p >= 205 : p <= -205);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) axis_position <= '0;
      else if (load) axis_position <= load_val;
      else if (motor_run && !at_stop) axis_position <= motor_dir ? p + 1 : p - 1;
   end
   // torque only rises while the motor pushes against the stopper
   assign motor_torque = at_stop ? 16'h0800 : 16'h0040;
   // reference marks spaced so no two rise within a few counts of a limit
   always_comb begin
      pins.near_home_switch = p >= 40 && p <= 56;
      pins.positive_overtravel_limit = p >= 200;
      pins.negative_overtravel_limit = p <= -200;
      pins.index_pulse = p[3:1] == 3'h0;
      pins.external_latch_two = p[3:1] == 3'h2;
      pins.external_latch_three = p[3:0] inside {4'hd, 4'he};
   end
endmodule // ahrs_amp_model

`default_nettype wire

/* File: tb/ahrs_sequencer_chk.sv */
// Purpose: port assertions of the home-return sequencer
// Assumes: pin edges reach the design two to four pclk late
// Notes: bound to every sequencer instance
`default_nettype none

module ahrs_sequencer_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // axis
   input wire logic [31:0] axis_position,
   input wire logic [15:0] motor_torque,
   input wire ahrs_pkg::ahrs_pins_type pins,
   input wire logic motor_run,
   input wire logic motor_dir,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wr_go;
   logic bad;
   logic [3:0] mtd_r;
   logic [3:0] mtd_nxt;
   logic [2:0] nh_age_r;
   logic [2:0] nh_age_nxt;
   logic [2:0] ix_age_r;
   logic [2:0] ix_age_nxt;
   ahrs_pkg::ahrs_pins_type pins_r;
   assign wr_go = psel && penable && pwrite && paddr == ahrs_pkg::ADDR_CTRL && pwdata[8];
   assign bad = pwdata[5] ? pwdata[3:0] inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h9, 4'ha, 4'hd, 4'he}
                          : pwdata[3:0] inside {4'h0, 4'h7};
   // ages saturate so a long-past rise never looks fresh
   always_comb begin
      mtd_nxt = (wr_go && !motor_run) ? pwdata[3:0] : mtd_r;
      nh_age_nxt = (nh_age_r == 3'h7) ? 3'h7 : nh_age_r + 3'h1;
      ix_age_nxt = (ix_age_r == 3'h7) ? 3'h7 : ix_age_r + 3'h1;
      if (pins.near_home_switch && !pins_r.near_home_switch) nh_age_nxt = 3'h0;
      if (pins.index_pulse && !pins_r.index_pulse) ix_age_nxt = 3'h0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mtd_r <= 4'h0;
         nh_age_r <= 3'h7;
         ix_age_r <= 3'h7;
         pins_r <= '0;
      end else begin
         mtd_r <= mtd_nxt;
         nh_age_r <= nh_age_nxt;
         ix_age_r <= ix_age_nxt;
         pins_r <= pins;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_in_access_a: assert property (psel && penable |-> pready) else $error("pready low in access");
   unmapped_err_a: assert property (psel && penable && paddr > 8'h1c |-> pslverr)
      else $error("no error on unmapped address");
   mapped_ok_a: assert property (psel && penable && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped address");
   run_cause_a: assert property ($rose(motor_run) |-> $past(wr_go) || $past(wr_go, 2))
      else $error("motor started without a start write");
   reject_still_a: assert property (wr_go && !motor_run && (bad || pwdata[3:0] == 4'hf) |=> !motor_run [*4])
      else $error("motor moved on rejected or data-set start");
   start_move_a: assert property (wr_go && !motor_run && !bad && pwdata[3:0] != 4'hf |-> ##[1:2] motor_run)
      else $error("supported method did not start the motor");
   nh_stop_a: assert property ($fell(motor_run) && mtd_r == 4'h0 |-> nh_age_r inside {[3'h1:3'h4]})
      else $error("near-home stop not tied to switch rise");
   ix_stop_a: assert property ($fell(motor_run) && mtd_r == 4'h8 |-> ix_age_r inside {[3'h1:3'h4]})
      else $error("index stop not tied to a fresh index rise");
   dir_turn_a: assert property (motor_run && $past(motor_run) && $changed(motor_dir)
      |-> mtd_r inside {[4'h4:4'h6], [4'hc:4'he]}) else $error("direction turned on a non-reversal method");
endmodule // ahrs_sequencer_chk

bind ahrs_sequencer ahrs_sequencer_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .axis_position(axis_position), .motor_torque(motor_torque), .pins(pins), .motor_run(motor_run),
   .motor_dir(motor_dir), .irq(irq));

`default_nettype wire

/* File: tb/ahrs_sequencer_bench.sv */
// Purpose: self-checking bench of the home-return sequencer
// Assumes: amplifier model on the axis side, apb master here
// Notes: reads are queued by the driver and judged by a monitor
`default_nettype none

module ahrs_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic signed [31:0] lo; logic signed [31:0] hi; logic er;} ahrs_exp_type;
   typedef struct {logic [3:0] m; logic d; logic pb; int s; int lo; int hi; int cv; logic er;} ahrs_row_type;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic load = 1'b0;
   logic [31:0] load_val = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] axis_position;
   logic [15:0] motor_torque;
   ahrs_pkg::ahrs_pins_type pins;
   logic motor_run;
   logic motor_dir;
   logic irq;
   int error_cnt = 0;
   int checks_done = 0;
   int s;
   ahrs_exp_type q[$];
   // windows allow for the pin synchroniser lag
   ahrs_row_type rows[18] = '{'{4'h0, 1, 1, 0, 41, 44, 1, 0}, '{4'h1, 1, 1, 0, 65, 68, 1, 0},
      '{4'h2, 1, 0, 0, 69, 72, 1, 0}, '{4'h3, 1, 0, 0, 62, 65, 1, 0}, '{4'h4, 0, 0, 150, 189, 192, -1, 0},
      '{4'h5, 0, 0, 150, 193, 196, -1, 0}, '{4'h6, 0, 0, 150, 186, 189, -1, 0}, '{4'h7, 1, 1, 150, 201, 204, 1, 0},
      '{4'h8, 1, 1, 0, 17, 20, 1, 0}, '{4'h9, 0, 0, 35, 17, 20, -1, 0}, '{4'ha, 0, 0, 35, 26, 29, -1, 0},
      '{4'hb, 0, 0, -150, -205, -205, 0, 0}, '{4'hc, 0, 0, -150, -191, -188, 1, 0},
      '{4'hd, 0, 0, -150, -203, -200, 1, 0}, '{4'he, 0, 0, -150, -194, -191, 1, 0},
      '{4'h2, 1, 1, 0, 0, 0, 0, 1}, '{4'h0, 1, 0, 0, 0, 0, 0, 1}, '{4'hd, 0, 1, 0, 0, 0, 0, 1}};

   ahrs_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .axis_position(axis_position), .motor_torque(motor_torque), .pins(pins), .motor_run(motor_run),
      .motor_dir(motor_dir), .irq(irq));
   ahrs_amp_model i_amp (.pclk(pclk), .presetn(presetn), .load(load), .load_val(load_val),
      .motor_run(motor_run), .motor_dir(motor_dir), .axis_position(axis_position),
      .motor_torque(motor_torque), .pins(pins));

   always #50 pclk = ~pclk;

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic cmp_rd(input ahrs_exp_type e, input logic [31:0] v, input logic se);
      checks_done++;
      if (^v === 1'bx || se !== e.er || $signed(v) < e.lo || $signed(v) > e.hi) begin
         $display("unexpected read %h: expected %0d..%0d err %b, seen %0d err %b", e.a, e.lo, e.hi, e.er,
            $signed(v), se);
         error_cnt++;
      end
   endtask

   task automatic cmp_irq(input logic exp);
      @(negedge pclk);
      checks_done++;
      if (irq !== exp) begin
         $display("unexpected irq: expected %b, seen %b", exp, irq);
         error_cnt++;
      end
      @(posedge pclk);
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && q.size() > 0) cmp_rd(q.pop_front(), prdata, pslverr);
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n == 20) begin
         error_cnt++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input int lo, input int hi, input logic er);
      q.push_back('{a, lo, hi, er});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic run(input ahrs_row_type r, input logic ie);
      int n;
      n = 0;
      load_val <= r.s;
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b1, ahrs_pkg::ADDR_INT_STAT, 32'h3);
      cmp_irq(1'b0);
      // the amplifier model has no pattern input; the row's pattern bit goes only to the control word
      apb(1'b1, ahrs_pkg::ADDR_CTRL, {23'h0, 1'b1, 2'h0, r.pb, r.d, r.m});
      repeat (3) @(posedge pclk);
      while (motor_run !== 1'b0 && n < 3000) begin
         n++;
         @(posedge pclk);
      end
      if (n == 3000) begin
         error_cnt++;
         summarize();
      end
      if (r.er) begin
         rd(ahrs_pkg::ADDR_STATUS, 4, 4, 1'b0);
         rd(ahrs_pkg::ADDR_INT_STAT, 2, 2, 1'b0);
      end else begin
         rd(ahrs_pkg::ADDR_STATUS, 2, 2, 1'b0);
         rd(ahrs_pkg::ADDR_INT_STAT, 1, 1, 1'b0);
         rd(ahrs_pkg::ADDR_HOME_POS, r.lo, r.hi, 1'b0);
         rd(ahrs_pkg::ADDR_COORD, r.cv, r.cv, 1'b0);
      end
      cmp_irq(ie);
      $display("test method %h dir %b pattern %b done", r.m, r.d, r.pb);
   endtask

   initial begin
      void'($urandom(63));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(ahrs_pkg::ADDR_CTRL, 0, 0, 1'b0);
      rd(ahrs_pkg::ADDR_STATUS, 0, 0, 1'b0);
      rd(ahrs_pkg::ADDR_INT_MASK, 0, 0, 1'b0);
      rd(ahrs_pkg::ADDR_TORQUE_THR, 65535, 65535, 1'b0);
      rd(ahrs_pkg::ADDR_CONTACT_CYC, 1, 1, 1'b0);
      rd(8'h20, 0, 0, 1'b1);
      $display("test register reset done");
      apb(1'b1, ahrs_pkg::ADDR_TORQUE_THR, 32'h400);
      apb(1'b1, ahrs_pkg::ADDR_CONTACT_CYC, 32'h8);
      // masked completion must stay quiet until unmasked
      s = int'($urandom_range(1000)) - 500;
      run('{4'hf, 1'b1, 1'b1, s, s, s, 0, 1'b0}, 1'b0);
      apb(1'b1, ahrs_pkg::ADDR_INT_MASK, 32'h3);
      cmp_irq(1'b1);
      foreach (rows[i]) run(rows[i], 1'b1);
      summarize();
   end
endmodule // ahrs_sequencer_bench

`default_nettype wire
